// File: rcr_top.sv
// Reset cause recorder with its AXI4-Lite register slave
// Overview of operation
// - Record loaded from real causes after reset
// - Pin reset sets bit 0, clears others
// - Other causes set flag, keep earlier flags
// - Bit 5 marks regulator power loss
// - Bit 2 marks brown-out detection
// - Bit 1 marks power-on reset
// - Bit 0 marks external reset pin
// - Bits 31:6 read-only, read back zero
// - Record sits at its own offset
module rcr_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Cause levels from the reset logic, held through the reset
  input  wire logic        pinDrivenResetCause,
  input  wire logic        powerOnResetCause,
  input  wire logic        brownoutResetCause,
  input  wire logic        watchdogResetCause,
  input  wire logic        softwareResetCause,
  input  wire logic        regulatorPowerLossCause,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Record has been loaded since the last reset
  output logic             recordLoaded
);
  logic [5:0]  causeAsync;   // Raw cause levels
  logic [5:0]  causeSync;    // Synchronised cause levels
  logic [5:0]  rec_r;        // The reset cause record, survives reset
  logic [5:0]  rec_nxt;
  logic        pend_r;       // Load still to be done after reset
  logic        pend_nxt;
  logic [1:0]  settle_r;     // Waits out the synchroniser latency
  logic [1:0]  settle_nxt;
  logic        loadNow;      // Capture the causes this cycle
  // Write channel state
  logic        awHeld_r;
  logic        awHeld_nxt;
  logic [11:0] awAddr_r;
  logic [11:0] awAddr_nxt;
  logic        wHeld_r;
  logic        wHeld_nxt;
  logic [31:0] wData_r;
  logic [31:0] wData_nxt;
  logic        wLane0_r;     // Byte lane 0 enabled
  logic        wLane0_nxt;
  logic        awready_r;
  logic        awready_nxt;
  logic        wready_r;
  logic        wready_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        doWrite;      // Both halves held, response slot free
  logic        recWrite;     // Write lands on the record
  // Read channel state
  logic        arready_r;
  logic        arready_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;

  // Cause levels come from outside the clock domain
  assign causeAsync[rcr_pkg::PIN_BIT]   = pinDrivenResetCause;
  assign causeAsync[rcr_pkg::POR_BIT]   = powerOnResetCause;
  assign causeAsync[rcr_pkg::BROWN_BIT] = brownoutResetCause;
  assign causeAsync[rcr_pkg::WDOG_BIT]  = watchdogResetCause;
  assign causeAsync[rcr_pkg::SOFT_BIT]  = softwareResetCause;
  assign causeAsync[rcr_pkg::REG_BIT]   = regulatorPowerLossCause;

  rcr_sync #(
    .WIDTH   (rcr_pkg::CAUSE_W)
  ) uSync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .asyncIn (causeAsync),
    .syncOut (causeSync)
  );

  // Load sequencing: wait for the synchronisers, then capture once
  always_comb
  begin
    settle_nxt = settle_r;
    pend_nxt   = pend_r;
    loadNow    = 1'b0;
    if (pend_r)
    begin
      if (settle_r != 2'h0)
        settle_nxt = settle_r - 2'h1;
      else
      begin
        loadNow  = 1'b1;
        pend_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      settle_r <= rcr_pkg::SETTLE_RST;
      pend_r   <= rcr_pkg::PEND_RST;
    end
    else
    begin
      settle_r <= settle_nxt;
      pend_r   <= pend_nxt;
    end
  end

  // Record next value; the load outranks a software write
  always_comb
  begin
    rec_nxt = rec_r;
    if (loadNow)
    begin
      if (causeSync[rcr_pkg::PIN_BIT])
        rec_nxt = rcr_pkg::PIN_ONLY;
      else
        // Power-on is sticky too; software clears by write
        rec_nxt = rec_r | causeSync;
    end
    else if (recWrite)
      rec_nxt = wData_r[5:0];
  end

  // No reset here on purpose: the record must outlive the reset
  always_ff @(posedge ref_clk)
  begin
    rec_r <= rec_nxt;
  end

  // Write channel: address and data accepted in either order
  assign doWrite  = awHeld_r && wHeld_r && !bvalid_r;
  assign recWrite = doWrite && wLane0_r &&
                    (awAddr_r[11:2] == rcr_pkg::REC_OFFSET[11:2]);

  always_comb
  begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt  = wHeld_r;
    wData_nxt  = wData_r;
    wLane0_nxt = wLane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    if (s_axi_awvalid && awready_r)
    begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      wHeld_nxt  = 1'b1;
      wData_nxt  = s_axi_wdata;
      wLane0_nxt = s_axi_wstrb[0];
    end
    if (doWrite)
    begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      if (awAddr_r[11:2] == rcr_pkg::REC_OFFSET[11:2])
        bresp_nxt = rcr_pkg::RESP_OKAY;
      else
        bresp_nxt = rcr_pkg::RESP_DECERR;  // Unmapped word
    end
    else if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    awready_nxt = !awHeld_nxt;
    wready_nxt  = !wHeld_nxt;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      awHeld_r  <= 1'b0;
      awAddr_r  <= 12'h000;
      wHeld_r   <= 1'b0;
      wData_r   <= 32'h00000000;
      wLane0_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
    end
    else
    begin
      awHeld_r  <= awHeld_nxt;
      awAddr_r  <= awAddr_nxt;
      wHeld_r   <= wHeld_nxt;
      wData_r   <= wData_nxt;
      wLane0_r  <= wLane0_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // Read channel: one read at a time, answered the next cycle
  always_comb
  begin
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_arvalid && arready_r)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      if (s_axi_araddr[11:2] == rcr_pkg::REC_OFFSET[11:2])
      begin
        rdata_nxt = {26'h0000000, rec_r};
        rresp_nxt = rcr_pkg::RESP_OKAY;
      end
      else
      begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = rcr_pkg::RESP_DECERR;
      end
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    else if (!rvalid_r)
      arready_nxt = 1'b1;  // Comes up after reset
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= 2'h0;
    end
    else
    begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign recordLoaded  = !pend_r;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_load_once: assert property ($fell(pend_r) |=> !pend_r [*4])
    else $error("record load repeated");
  chk_pin_clears: assert property (loadNow && causeSync[0]
      |=> rec_r == 6'h01)
    else $error("pin reset did not clear other causes");
  chk_sticky: assert property (loadNow && !causeSync[0]
      |=> rec_r == ($past(rec_r) | $past(causeSync)))
    else $error("earlier causes lost");
  chk_reg_bit: assert property (loadNow && !causeSync[0] && causeSync[5]
      |=> rec_r[5])
    else $error("regulator cause not in bit 5");
  chk_brown_bit: assert property (loadNow && !causeSync[0] && causeSync[2]
      |=> rec_r[2])
    else $error("brown-out cause not in bit 2");
  chk_por_bit: assert property (loadNow && !causeSync[0] && causeSync[1]
      |=> rec_r[1])
    else $error("power-on cause not in bit 1");
  chk_soft_wdog: assert property (loadNow && !causeSync[0]
      |=> rec_r[4:3] == ($past(rec_r[4:3]) | $past(causeSync[4:3])))
    else $error("software or watchdog cause misplaced");
  chk_upper_zero: assert property (rvalid_r |-> rdata_r[31:6] == 26'h0)
    else $error("reserved bits not zero");
  chk_read_decode: assert property (s_axi_arvalid && arready_r &&
      s_axi_araddr[11:2] != 10'h017 |=> rresp_r == 2'h3)
    else $error("unmapped read not refused");
  chk_write_replace: assert property (recWrite && !loadNow
      |=> rec_r == $past(wData_r[5:0]))
    else $error("software write did not replace flags");
  chk_bresp_follows: assert property (doWrite |=> bvalid_r)
    else $error("write response missing");

  cov_pin_load:   cover property (loadNow && causeSync[0]);
  cov_sticky:     cover property (loadNow && causeSync[3] && rec_r[2]);
  cov_rec_write:  cover property (recWrite);
  cov_rec_read:   cover property (rvalid_r && rresp_r == 2'h0);
endmodule : rcr_top

// File: rcr_pkg.sv
// Constants shared by the reset cause recorder files
package rcr_pkg;
  // Register map
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] REC_OFFSET  = 12'h05c;  // Record word address
  // Field positions in the record
  localparam int          PIN_BIT     = 0;
  localparam int          POR_BIT     = 1;
  localparam int          BROWN_BIT   = 2;
  localparam int          WDOG_BIT    = 3;
  localparam int          SOFT_BIT    = 4;
  localparam int          REG_BIT     = 5;
  localparam int          CAUSE_W     = 6;
  // Value the record takes after a pin-driven reset
  localparam logic [5:0]  PIN_ONLY    = 6'h01;
  // Cycles the synchronisers need before the causes are trusted
  localparam logic [1:0]  SETTLE_CNT  = 2'h2;
  // Value of the settle counter and load flag after reset
  localparam logic [1:0]  SETTLE_RST  = 2'h2;
  localparam logic        PEND_RST    = 1'b1;
  // AXI response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
endpackage : rcr_pkg

// File: rcr_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels
module rcr_sync #(
  parameter int WIDTH = 6
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;  // First stage, read only by the second
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;  // Second stage
  logic [WIDTH-1:0] sync_nxt;

  // Refuse a width the logic cannot serve
  if (WIDTH < 1)
  begin : gBadWidth
    $error("rcr_sync: WIDTH must be at least 1");
  end

  // Next values: plain shift through two stages
  always_comb
  begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end

  // Registers only
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;
endmodule : rcr_sync

// File: test_reset_cause_recorder.sv
// Self-checking testbench for the reset cause recorder
`define CHK(g, e) \
  begin \
    numChecks++; \
    if ((g) !== (e)) \
    begin \
      badCount++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module test_reset_cause_recorder;
  timeunit 1ns;
  timeprecision 100ps;

  // One row: cause levels held through a reset and the record they leave
  typedef struct packed
  {
    logic [5:0] cause;
    logic [5:0] expRec;
  } rcr_row_t;

  localparam logic [11:0] REC_ADDR = rcr_pkg::REC_OFFSET;

  // Rows run in order: each non-pin record builds on the one before
  // The first row is a pin reset so the record starts from a known value
  rcr_row_t rows [10] = '{'{6'h01, 6'h01}, '{6'h02, 6'h03},
    '{6'h04, 6'h07}, '{6'h08, 6'h0f}, '{6'h10, 6'h1f}, '{6'h20, 6'h3f},
    '{6'h01, 6'h01}, '{6'h25, 6'h01}, '{6'h0a, 6'h0b}, '{6'h00, 6'h0b}};

  logic        ref_clk;   // 125 MHz clock
  logic        reset;     // Async reset, active high
  logic [5:0]  cause;     // Cause levels, bit order as in the record
  logic [11:0] awAddr;    // Write address channel
  logic        awValid;
  logic        awReady;
  logic [31:0] wData;     // Write data channel
  logic [3:0]  wStrb;
  logic        wValid;
  logic        wReady;
  logic [1:0]  bResp;     // Write response channel
  logic        bValid;
  logic        bReady;
  logic [11:0] arAddr;    // Read address channel
  logic        arValid;
  logic        arReady;
  logic [31:0] rData;     // Read data channel
  logic [1:0]  rResp;
  logic        rValid;
  logic        rReady;
  logic        recordLoaded;
  int          badCount;  // Mismatches seen
  int          numChecks; // Comparisons made
  logic [31:0] rdVal;
  logic [1:0]  rsp;

  rcr_top DUT (
    .ref_clk                 (ref_clk),
    .reset                   (reset),
    .pinDrivenResetCause     (cause[0]),
    .powerOnResetCause       (cause[1]),
    .brownoutResetCause      (cause[2]),
    .watchdogResetCause      (cause[3]),
    .softwareResetCause      (cause[4]),
    .regulatorPowerLossCause (cause[5]),
    .s_axi_awaddr            (awAddr),
    .s_axi_awvalid           (awValid),
    .s_axi_awready           (awReady),
    .s_axi_wdata             (wData),
    .s_axi_wstrb             (wStrb),
    .s_axi_wvalid            (wValid),
    .s_axi_wready            (wReady),
    .s_axi_bresp             (bResp),
    .s_axi_bvalid            (bValid),
    .s_axi_bready            (bReady),
    .s_axi_araddr            (arAddr),
    .s_axi_arvalid           (arValid),
    .s_axi_arready           (arReady),
    .s_axi_rdata             (rData),
    .s_axi_rresp             (rResp),
    .s_axi_rvalid            (rValid),
    .s_axi_rready            (rReady),
    .recordLoaded            (recordLoaded)
  );

  // Free-running clock
  always #4 ref_clk = ~ref_clk;

  // Verdict and end of run
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // Reset with causes held until the record has been captured
  task automatic doReset(input logic [5:0] c);
    int n;
    n = 0;
    @(posedge ref_clk);
    reset <= 1'b1;
    cause <= c;
    repeat (6) @(posedge ref_clk);
    `CHK({awReady, bValid, rValid, recordLoaded}, 4'h0)
    reset <= 1'b0;
    while (recordLoaded !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK(recordLoaded, 1'b1)
    cause <= 6'h00;
  endtask : doReset

  // AXI4-Lite write; ready sampled as it stood at each edge
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
    @(posedge ref_clk);
    awAddr  <= a;
    wData   <= d;
    wStrb   <= s;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (awValid && awReady)
        awValid <= 1'b0;
      if (wValid && wReady)
        wValid <= 1'b0;
      if (bValid && bReady)
      begin
        r = bResp;
        bReady <= 1'b0;
        break;
      end
    end
  endtask : axiWrite

  // AXI4-Lite read
  task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    @(posedge ref_clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (arValid && arReady)
        arValid <= 1'b0;
      if (rValid && rReady)
      begin
        d = rData;
        r = rResp;
        rReady <= 1'b0;
        break;
      end
    end
  endtask : axiRead

  // Read the record and compare its six flags
  task automatic chkRec(input logic [5:0] e);
    axiRead(REC_ADDR, rdVal, rsp);
    `CHK(rdVal, {26'h0, e})
    `CHK(rsp, rcr_pkg::RESP_OKAY)
  endtask : chkRec

  // Watchdog: the whole run needs well under 3000 cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    badCount++;
    summarize();
  end

  // Main sequence
  initial
  begin
    ref_clk = 1'b0;
    reset   = 1'b1;
    cause   = 6'h00;
    {awAddr, awValid, wData, wStrb, wValid, bReady} = '0;
    {arAddr, arValid, rReady} = '0;
    badCount  = 0;
    numChecks = 0;
    // Cause table: pin clears, every other cause accumulates
    foreach (rows[i])
    begin
      doReset(rows[i].cause);
      chkRec(rows[i].expRec);
    end
    // Software write replaces the flags; reserved bits stay zero
    axiWrite(REC_ADDR, 32'h00000015, 4'hf, rsp);
    `CHK(rsp, rcr_pkg::RESP_OKAY)
    chkRec(6'h15);
    axiWrite(REC_ADDR, 32'hffffffff, 4'hf, rsp);
    chkRec(6'h3f);
    // Write whose low byte is not enabled leaves the record alone
    axiWrite(REC_ADDR, 32'h00000000, 4'he, rsp);
    chkRec(6'h3f);
    // Neighbouring words are not the record
    axiWrite(12'h060, 32'h00000000, 4'hf, rsp);
    `CHK(rsp, rcr_pkg::RESP_DECERR)
    axiRead(12'h058, rdVal, rsp);
    `CHK(rsp, rcr_pkg::RESP_DECERR)
    `CHK(rdVal, 32'h00000000)
    chkRec(6'h3f);
    // A written value survives and joins a later non-pin cause
    axiWrite(REC_ADDR, 32'h00000004, 4'hf, rsp);
    doReset(6'h20);
    chkRec(6'h24);
    // Pin reset together with software cause leaves only the pin flag
    doReset(6'h11);
    chkRec(6'h01);
    summarize();
  end
endmodule : test_reset_cause_recorder
